// file: rsr_pkg.sv
// constants for the rail setpoint and sequencing register block
package rsr_pkg;

  // register offsets
  localparam logic [7:0] ADDR_BUCK_BOOST = 8'h19;
  localparam logic [7:0] ADDR_RAMP_CTRL = 8'h1a;
  localparam logic [7:0] ADDR_LINEAR_REG = 8'h1b;
  localparam logic [7:0] ADDR_DLY_SELECT = 8'h20;
  localparam logic [7:0] ADDR_DLY_FACTOR = 8'h21;

  // field positions and widths
  localparam int SETPT_W = 6;
  localparam int STEP_W = 3;
  localparam int RAMP_GO_BIT = 7;
  localparam int RAMP_BYPASS_BIT = 6;
  localparam int PSKIP_BIT = 7;
  localparam int DLY_FACTOR_BIT = 7;
  localparam int TMR_W = 24;

  // reset values
  localparam logic [SETPT_W-1:0] BUCK_BOOST_RST = 6'h32;
  localparam logic PSKIP_RST = 1'b1;
  localparam logic [STEP_W-1:0] STEP_RST = 3'h6;
  localparam logic [SETPT_W-1:0] LINEAR_REG_RST = 6'h1f;
  localparam logic [7:0] DLY_SELECT_RST = 8'h00;
  localparam logic DLY_FACTOR_RST = 1'b0;

  // encodings
  localparam logic [STEP_W-1:0] STEP_IMMEDIATE = 3'h7;
  localparam logic [3:0] STROBE_FIRST = 4'h1;
  localparam logic [3:0] STROBE_LAST = 4'ha;
  localparam logic [3:0] STROBE_RAIL_MIN = 4'h3;
  localparam int N_RAILS = 5;

  // timing
  localparam int CLK_MHZ = 20;
  localparam int BASE_STEP_NS = 2500;
  localparam int BASE_STEP_CYC = BASE_STEP_NS * CLK_MHZ / 1000;
  localparam int DLY_SHORT_MS = 2;
  localparam int DLY_LONG_MS = 5;
  localparam int BLANK_MS = 5;
  localparam int DN_FACTOR = 10;
  localparam int DLY_SHORT_CYC = DLY_SHORT_MS * CLK_MHZ * 1000;
  localparam int DLY_LONG_CYC = DLY_LONG_MS * CLK_MHZ * 1000;
  localparam int BLANK_CYC = BLANK_MS * CLK_MHZ * 1000;

endpackage

// file: rsr_timer.sv
// loadable down counter that pulses when its interval ends
`timescale 1ns/1ps
module rsr_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_load,
  input wire logic [rsr_pkg::TMR_W-1:0] i_count,
  // status
  output logic o_busy,
  output logic o_done
);

  logic [rsr_pkg::TMR_W-1:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        cnt_q <= i_count;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
        o_done <= (cnt_q == {{(rsr_pkg::TMR_W-1){1'b0}}, 1'b1});
      end
    end
  end

  assign o_busy = (cnt_q != '0);

endmodule

// file: rsr_ramp.sv
// one core rail: walks the active code toward a latched target
`timescale 1ns/1ps
module rsr_ramp (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_start,
  input wire logic [rsr_pkg::SETPT_W-1:0] i_target,
  input wire logic i_step,
  input wire logic i_immediate,
  // state
  output logic [rsr_pkg::SETPT_W-1:0] o_code,
  output logic o_busy
);

  logic [rsr_pkg::SETPT_W-1:0] tgt_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tgt_q <= '0;
      o_code <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      tgt_q <= i_target;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      if (o_code == tgt_q) begin
        o_busy <= 1'b0;
      end else if (i_immediate) begin
        o_code <= tgt_q;
      end else if (i_step) begin
        // one code per step interval
        o_code <= (o_code < tgt_q) ? o_code + 1'b1 : o_code - 1'b1;
      end
    end
  end

endmodule

// file: rsr_regs.sv
// rail setpoint, ramp control and power sequencing registers
//
// Behaviour
// - buck-boost setpoint bits 5:0, reset 32h
// - ramp control drives only both core rails
// - trigger bit write starts both core ramps
// - trigger bit self-clears when transition completes
// - bypass bit ramps on each setpoint update
// - step-time code selects time per step
// - step code 7h applies setpoint at once
// - linear setpoint bits 5:0, reset 1Fh
// - linear setpoint write blanks monitoring 5 ms
// - linear and delay registers need unlock
// - eight selectors pick 2 or 5 ms
// - multiplier bit scales power-down delays tenfold
// - power-up delays never scaled
// - strobe codes 3h..Ah enable rails
`timescale 1ns/1ps
module rsr_regs #(
  parameter int P_DLY_SHORT_CYC = rsr_pkg::DLY_SHORT_CYC,
  parameter int P_DLY_LONG_CYC = rsr_pkg::DLY_LONG_CYC,
  parameter int P_BLANK_CYC = rsr_pkg::BLANK_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port from the serial interface logic
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_unlocked,
  output logic [7:0] o_rd_data,
  // core rail setpoints held in the neighbouring registers
  input wire logic [rsr_pkg::SETPT_W-1:0] i_core_a_setpoint,
  input wire logic [rsr_pkg::SETPT_W-1:0] i_core_b_setpoint,
  input wire logic i_core_setpoint_upd,
  // sequencing
  input wire logic i_pwr_up_req,
  input wire logic i_pwr_dn_req,
  input wire logic [rsr_pkg::N_RAILS*4-1:0] i_rail_strobe_codes,
  output logic o_strobe,
  output logic [3:0] o_strobe_num,
  output logic o_seq_busy,
  output logic [rsr_pkg::N_RAILS-1:0] o_rail_en,
  // regulator controls
  output logic [rsr_pkg::SETPT_W-1:0] o_core_a_code,
  output logic [rsr_pkg::SETPT_W-1:0] o_core_b_code,
  output logic o_ramp_busy,
  output logic [rsr_pkg::SETPT_W-1:0] o_buck_boost_code,
  output logic o_buck_boost_pskip,
  output logic [rsr_pkg::SETPT_W-1:0] o_linear_code,
  output logic o_linear_blank
);

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_STROBE = 3'b010,
    SEQ_WAIT = 3'b100
  } rsr_seq_t;

  logic go_q;
  logic bypass_q;
  logic [rsr_pkg::STEP_W-1:0] step_sel_q;
  logic [7:0] dly_sel_q;
  logic dly_factor_q;
  logic [5:0] base_cnt_q;
  logic [6:0] step_cnt_q;
  logic step_tick_q;
  logic ramp_start;
  logic busy_a;
  logic busy_b;
  logic wr_ramp;
  logic wr_linear;
  logic wr_locked_ok;
  logic [6:0] step_limit;
  logic blank_load;
  logic blank_busy;
  rsr_seq_t seq_state_q;
  logic seq_up_q;
  logic [3:0] seq_idx_q;
  logic [3:0] seq_level_q;
  logic dly_load;
  logic [rsr_pkg::TMR_W-1:0] dly_count;
  logic dly_done;
  logic dly_bit;

  assign wr_ramp = i_wr_en && (i_addr == rsr_pkg::ADDR_RAMP_CTRL);
  assign wr_linear = i_wr_en && (i_addr == rsr_pkg::ADDR_LINEAR_REG);
  assign wr_locked_ok = i_wr_en && i_unlocked;

  // a trigger write or, in bypass, a setpoint update starts both core ramps
  assign ramp_start = (wr_ramp && i_wr_data[rsr_pkg::RAMP_GO_BIT])
    || (bypass_q && i_core_setpoint_upd);

  // ramp control register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bypass_q <= 1'b0;
      step_sel_q <= rsr_pkg::STEP_RST;
    end else if (wr_ramp) begin
      bypass_q <= i_wr_data[rsr_pkg::RAMP_BYPASS_BIT];
      step_sel_q <= i_wr_data[rsr_pkg::STEP_W-1:0];
    end
  end

  // trigger bit: writing 0 leaves it alone; a new trigger wins over completion
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      go_q <= 1'b0;
    end else if (wr_ramp && i_wr_data[rsr_pkg::RAMP_GO_BIT]) begin
      go_q <= 1'b1;
    end else if (go_q && !busy_a && !busy_b && !ramp_start) begin
      go_q <= 1'b0;
    end
  end

  // 2.5 us base tick; slower step codes count powers of two of it
  always_comb begin
    case (step_sel_q)
      3'h0: step_limit = 7'h40;
      3'h1: step_limit = 7'h20;
      3'h2: step_limit = 7'h10;
      3'h3: step_limit = 7'h08;
      3'h4: step_limit = 7'h04;
      3'h5: step_limit = 7'h02;
      default: step_limit = 7'h01;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_cnt_q <= '0;
      step_cnt_q <= '0;
      step_tick_q <= 1'b0;
    end else begin
      step_tick_q <= 1'b0;
      // restart on each ramp start so the first step gets a full interval
      if (ramp_start) begin
        base_cnt_q <= '0;
        step_cnt_q <= '0;
      end else if (base_cnt_q == 6'(rsr_pkg::BASE_STEP_CYC - 1)) begin
        base_cnt_q <= '0;
        if (step_cnt_q + 7'h01 >= step_limit) begin
          step_cnt_q <= '0;
          step_tick_q <= 1'b1;
        end else begin
          step_cnt_q <= step_cnt_q + 7'h01;
        end
      end else begin
        base_cnt_q <= base_cnt_q + 6'h01;
      end
    end
  end

  // only the two core rails see ramp control
  rsr_ramp u_ramp_a (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_start(ramp_start),
    .i_target(i_core_a_setpoint),
    .i_step(step_tick_q),
    .i_immediate(step_sel_q == rsr_pkg::STEP_IMMEDIATE),
    .o_code(o_core_a_code),
    .o_busy(busy_a)
  );

  rsr_ramp u_ramp_b (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_start(ramp_start),
    .i_target(i_core_b_setpoint),
    .i_step(step_tick_q),
    .i_immediate(step_sel_q == rsr_pkg::STEP_IMMEDIATE),
    .o_code(o_core_b_code),
    .o_busy(busy_b)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ramp_busy <= 1'b0;
    end else begin
      o_ramp_busy <= busy_a || busy_b || ramp_start;
    end
  end

  // buck-boost setpoint and pulse-skip bit; reserved codes are the host's to avoid
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_buck_boost_code <= rsr_pkg::BUCK_BOOST_RST;
      o_buck_boost_pskip <= rsr_pkg::PSKIP_RST;
    end else if (i_wr_en && i_addr == rsr_pkg::ADDR_BUCK_BOOST) begin
      o_buck_boost_code <= i_wr_data[rsr_pkg::SETPT_W-1:0];
      o_buck_boost_pskip <= i_wr_data[rsr_pkg::PSKIP_BIT];
    end
  end

  // protected registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_linear_code <= rsr_pkg::LINEAR_REG_RST;
      dly_sel_q <= rsr_pkg::DLY_SELECT_RST;
      dly_factor_q <= rsr_pkg::DLY_FACTOR_RST;
    end else if (wr_locked_ok) begin
      if (i_addr == rsr_pkg::ADDR_LINEAR_REG) begin
        o_linear_code <= i_wr_data[rsr_pkg::SETPT_W-1:0];
      end
      if (i_addr == rsr_pkg::ADDR_DLY_SELECT) begin
        dly_sel_q <= i_wr_data;
      end
      if (i_addr == rsr_pkg::ADDR_DLY_FACTOR) begin
        dly_factor_q <= i_wr_data[rsr_pkg::DLY_FACTOR_BIT];
      end
    end
  end

  // blanking follows any write attempt, so a refused write still masks the monitor
  assign blank_load = wr_linear;

  rsr_timer u_blank_tmr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(blank_load),
    .i_count(rsr_pkg::TMR_W'(P_BLANK_CYC)),
    .o_busy(blank_busy),
    .o_done()
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_linear_blank <= 1'b0;
    end else begin
      o_linear_blank <= blank_load || blank_busy;
    end
  end

  // delay after strobe n is selector n; going down, the one before strobe n
  always_comb begin
    dly_bit = 1'b0;
    if (seq_up_q) begin
      if (seq_idx_q <= 4'h8) begin
        dly_bit = dly_sel_q[3'(seq_idx_q - 4'h1)];
      end
    end else if (seq_idx_q >= 4'h2 && seq_idx_q <= 4'h9) begin
      dly_bit = dly_sel_q[3'(seq_idx_q - 4'h2)];
    end
    dly_count = dly_bit ? rsr_pkg::TMR_W'(P_DLY_LONG_CYC) : rsr_pkg::TMR_W'(P_DLY_SHORT_CYC);
    // the factor only stretches power-down waits
    if (!seq_up_q && dly_factor_q) begin
      dly_count = rsr_pkg::TMR_W'(dly_count * rsr_pkg::DN_FACTOR);
    end
  end

  assign dly_load = (seq_state_q == SEQ_STROBE)
    && !(seq_up_q ? seq_idx_q == rsr_pkg::STROBE_LAST : seq_idx_q == rsr_pkg::STROBE_FIRST);

  rsr_timer u_seq_tmr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(dly_load),
    .i_count(dly_count),
    .o_busy(),
    .o_done(dly_done)
  );

  // sequencer; requests are ignored while a sequence runs
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_state_q <= SEQ_IDLE;
      seq_up_q <= 1'b1;
      seq_idx_q <= rsr_pkg::STROBE_FIRST;
      seq_level_q <= 4'h0;
      o_strobe <= 1'b0;
      o_strobe_num <= 4'h0;
      o_seq_busy <= 1'b0;
    end else begin
      o_strobe <= 1'b0;
      case (seq_state_q)
        SEQ_IDLE: begin
          o_seq_busy <= i_pwr_up_req || i_pwr_dn_req;
          if (i_pwr_up_req) begin
            seq_up_q <= 1'b1;
            seq_idx_q <= rsr_pkg::STROBE_FIRST;
            seq_state_q <= SEQ_STROBE;
          end else if (i_pwr_dn_req) begin
            seq_up_q <= 1'b0;
            seq_idx_q <= rsr_pkg::STROBE_LAST;
            seq_state_q <= SEQ_STROBE;
          end
        end
        SEQ_STROBE: begin
          o_strobe <= 1'b1;
          o_strobe_num <= seq_idx_q;
          seq_level_q <= seq_up_q ? seq_idx_q : seq_idx_q - 4'h1;
          seq_state_q <= dly_load ? SEQ_WAIT : SEQ_IDLE;
          o_seq_busy <= dly_load;
        end
        SEQ_WAIT: begin
          if (dly_done) begin
            seq_idx_q <= seq_up_q ? seq_idx_q + 4'h1 : seq_idx_q - 4'h1;
            seq_state_q <= SEQ_STROBE;
          end
        end
        default: begin
          seq_state_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // a rail is on while the sequence has passed its strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rail_en <= '0;
    end else begin
      for (int r = 0; r < rsr_pkg::N_RAILS; r++) begin
        o_rail_en[r] <= (i_rail_strobe_codes[r*4 +: 4] >= rsr_pkg::STROBE_RAIL_MIN)
          && (i_rail_strobe_codes[r*4 +: 4] <= rsr_pkg::STROBE_LAST)
          && (i_rail_strobe_codes[r*4 +: 4] <= seq_level_q);
      end
    end
  end

  // read port; reserved bits and unmapped offsets read zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        rsr_pkg::ADDR_BUCK_BOOST: o_rd_data <= {o_buck_boost_pskip, 1'b0, o_buck_boost_code};
        rsr_pkg::ADDR_RAMP_CTRL: o_rd_data <= {go_q, bypass_q, 3'h0, step_sel_q};
        rsr_pkg::ADDR_LINEAR_REG: o_rd_data <= {2'h0, o_linear_code};
        rsr_pkg::ADDR_DLY_SELECT: o_rd_data <= dly_sel_q;
        rsr_pkg::ADDR_DLY_FACTOR: o_rd_data <= {dly_factor_q, 7'h00};
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

endmodule

// file: rsr_regs_props.sv
// assertion checker for the rail setpoint and sequencing registers
`timescale 1ns/1ps
module rsr_regs_props #(
  parameter int P_BLANK_CYC = rsr_pkg::BLANK_CYC
) (
  // clock, reset and register port
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_unlocked,
  input wire logic [7:0] o_rd_data,
  // rail outputs
  input wire logic o_strobe,
  input wire logic o_ramp_busy,
  input wire logic [rsr_pkg::SETPT_W-1:0] o_core_a_code,
  input wire logic [rsr_pkg::SETPT_W-1:0] o_buck_boost_code,
  input wire logic [rsr_pkg::SETPT_W-1:0] o_linear_code,
  input wire logic o_linear_blank
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic lin_wr;
  int blank_cnt_q;
  assign lin_wr = i_wr_en && i_addr == rsr_pkg::ADDR_LINEAR_REG;
  // a rewrite restarts the window, so the count restarts too
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      blank_cnt_q <= 0;
    end else if (lin_wr) begin
      blank_cnt_q <= 0;
    end else if (o_linear_blank) begin
      blank_cnt_q <= blank_cnt_q + 1;
    end
  end
  AST_BB_WR: assert property (i_wr_en && i_addr == rsr_pkg::ADDR_BUCK_BOOST |=>
    o_buck_boost_code == $past(i_wr_data[5:0])) else $error("buck-boost code not stored");
  AST_BB_HOLD: assert property ($changed(o_buck_boost_code) |->
    $past(i_wr_en && i_addr == rsr_pkg::ADDR_BUCK_BOOST)) else $error("buck-boost code moved alone");
  AST_LIN_WR: assert property (lin_wr && i_unlocked |=>
    o_linear_code == $past(i_wr_data[5:0])) else $error("linear code not stored");
  AST_LIN_LOCK: assert property (lin_wr && !i_unlocked |=> $stable(o_linear_code))
    else $error("locked linear write took effect");
  AST_BLANK_GO: assert property (lin_wr |=> o_linear_blank) else $error("blanking not started");
  AST_BLANK_LEN: assert property ($fell(o_linear_blank) |-> blank_cnt_q == P_BLANK_CYC + 1)
    else $error("blanking length wrong");
  AST_RAMP_MOVE: assert property ($changed(o_core_a_code) |-> $past(o_ramp_busy) || $past(i_wr_en, 2))
    else $error("core code moved outside a ramp");
  AST_RD_RSV: assert property (i_rd_en && i_addr == rsr_pkg::ADDR_RAMP_CTRL |=> o_rd_data[5:3] == 3'h0)
    else $error("reserved ramp bits not zero");
  AST_RD_LIN: assert property (i_rd_en && i_addr == rsr_pkg::ADDR_LINEAR_REG |=>
    o_rd_data == {2'h0, $past(o_linear_code)}) else $error("linear readback wrong");
  AST_STROBE_ONE: assert property (o_strobe |=> !o_strobe) else $error("strobe longer than one cycle");
  cover property (o_strobe);
  cover property ($rose(o_ramp_busy));
  cover property ($fell(o_linear_blank));
endmodule
bind rsr_regs rsr_regs_props #(.P_BLANK_CYC(P_BLANK_CYC)) u_props (.*);

// file: rsr_host.sv
// host model driving the register port and the core setpoints
`timescale 1ns/1ps
module rsr_host (
  // clock
  input wire logic i_clk,
  // register port
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  output logic o_unlocked,
  input wire logic [7:0] i_rd_data,
  // core setpoints
  output logic [5:0] o_sp_a,
  output logic [5:0] o_sp_b,
  output logic o_sp_upd
);
  initial begin
    {o_wr_en, o_rd_en, o_unlocked, o_sp_upd} = 4'h0;
    {o_addr, o_wr_data} = 16'h0;
    {o_sp_a, o_sp_b} = 12'h0;
  end
  // tasks are entered and left 1 ns after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    logic [7:0] v;
    v = d;
    if (a == rsr_pkg::ADDR_BUCK_BOOST && v[5:0] > 6'h34) v[5:0] = 6'h34;
    o_addr = a;
    o_wr_data = v;
    o_unlocked = u;
    o_wr_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    d = i_rd_data;
    @(posedge i_clk);
    #1;
  endtask
  // a new code only lands once go or bypass is set; core pulse skip is taken as cleared before lowering
  task automatic setpt(input logic [5:0] a, input logic [5:0] b);
    o_sp_a = a;
    o_sp_b = b;
    o_sp_upd = 1'b1;
    @(posedge i_clk);
    #1;
    o_sp_upd = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
endmodule

// file: tb_top.sv
// self-checking bench for the rail setpoint and sequencing registers
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [7:0] d; logic u; logic [7:0] e;} rsr_row_t;
  logic i_clk, i_rst_b, i_wr_en, i_rd_en, i_unlocked, i_core_setpoint_upd, i_pwr_up_req, i_pwr_dn_req;
  logic o_strobe, o_seq_busy, o_ramp_busy, o_buck_boost_pskip, o_linear_blank;
  logic [7:0] i_addr, i_wr_data, o_rd_data, rv;
  logic [5:0] i_core_a_setpoint, i_core_b_setpoint, o_core_a_code, o_core_b_code, o_buck_boost_code;
  logic [5:0] o_linear_code, tg;
  logic [19:0] i_rail_strobe_codes;
  logic [3:0] o_strobe_num;
  logic [4:0] o_rail_en;
  logic [7:0] sel = 8'ha5;
  int error_cnt = 0, total_checks = 0, cyc = 0, t;
  logic [7:0] rst_a[6] = '{8'h19, 8'h1a, 8'h1b, 8'h20, 8'h21, 8'h30};
  logic [7:0] rst_e[6] = '{8'hb2, 8'h06, 8'h1f, 8'h00, 8'h00, 8'h00};
  rsr_row_t rows[9] = '{'{8'h19, 8'hc5, 1, 8'h85}, '{8'h1a, 8'h3d, 1, 8'h05}, '{8'h1b, 8'h05, 0, 8'h1f},
    '{8'h1b, 8'he5, 1, 8'h25}, '{8'h20, 8'ha5, 1, 8'ha5}, '{8'h20, 8'h00, 0, 8'ha5},
    '{8'h21, 8'hff, 1, 8'h80}, '{8'h21, 8'h00, 0, 8'h80}, '{8'h30, 8'hff, 1, 8'h00}};
  rsr_regs #(.P_DLY_SHORT_CYC(20), .P_DLY_LONG_CYC(50), .P_BLANK_CYC(50)) dut (.*);
  rsr_host host (.i_clk(i_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data),
    .o_unlocked(i_unlocked), .i_rd_data(o_rd_data), .o_sp_a(i_core_a_setpoint), .o_sp_b(i_core_b_setpoint),
    .o_sp_upd(i_core_setpoint_upd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wait_code(input logic [5:0] c, output int n);
    n = 0;
    while (o_core_a_code !== c && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  // gaps are measured strobe to strobe; a request during a run must be ignored
  task automatic run_seq(input logic up);
    int j;
    int d;
    i_pwr_up_req = up;
    i_pwr_dn_req = !up;
    tick(1);
    i_pwr_up_req = 1'b0;
    i_pwr_dn_req = 1'b0;
    t = 1;
    for (int k = 0; k < 10; k++) begin
      while (o_strobe !== 1'b1 && t < 2000) begin
        tick(1);
        t++;
      end
      chk({4'h0, o_strobe_num}, up ? 8'(k + 1) : 8'(10 - k));
      if (k > 0) begin
        j = up ? k : 10 - k;
        d = (j < 9 && sel[j-1]) ? 50 : 20;
        d = up ? d : d * 10;
        chk_rng(t, d + 1, d + 3);
      end else begin
        chk({7'h0, o_seq_busy}, 8'h01);
      end
      i_pwr_dn_req = up && k == 2;
      tick(1);
      i_pwr_dn_req = 1'b0;
      t = 1;
    end
    tick(3);
    chk({7'h0, o_seq_busy}, 8'h00);
    chk({3'h0, o_rail_en}, up ? 8'h0b : 8'h00);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    i_rst_b = 1'b0;
    {i_pwr_up_req, i_pwr_dn_req} = 2'h0;
    i_rail_strobe_codes = 20'hb72a3;
    tick(5);
    i_rst_b = 1'b1;
    chk({7'h0, o_buck_boost_pskip}, 8'h01);
    foreach (rst_a[i]) begin
      host.rd(rst_a[i], rv);
      chk(rv, rst_e[i]);
    end
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d, rows[i].u);
      host.rd(rows[i].a, rv);
      chk(rv, rows[i].e);
    end
    chk({2'h0, o_linear_code}, 8'h25);
    chk({7'h0, o_linear_blank}, 8'h01);
    // one code per ramp keeps the slow step codes affordable
    for (int c = 0; c < 7; c++) begin
      tg = o_core_a_code + 6'h01;
      host.setpt(tg, tg);
      host.wr(rsr_pkg::ADDR_RAMP_CTRL, {5'h10, 3'(c)}, 1'b1);
      host.rd(rsr_pkg::ADDR_RAMP_CTRL, rv);
      chk(rv, {5'h10, 3'(c)});
      chk({7'h0, o_ramp_busy}, 8'h01);
      wait_code(tg, t);
      chk_rng(t + 3, (64 >> c) * 50 - 3, (64 >> c) * 50 + 3);
      chk({2'h0, o_core_b_code}, {2'h0, tg});
      tick(3);
      host.rd(rsr_pkg::ADDR_RAMP_CTRL, rv);
      chk(rv, {5'h00, 3'(c)});
    end
    host.setpt(6'h20, 6'h10);
    host.wr(rsr_pkg::ADDR_RAMP_CTRL, 8'h87, 1'b1);
    tick(1);
    chk({o_core_a_code, 2'h0}, 8'h80);
    chk({2'h0, o_core_b_code}, 8'h10);
    host.wr(rsr_pkg::ADDR_RAMP_CTRL, 8'h46, 1'b1);
    host.setpt(6'h1f, 6'h10);
    wait_code(6'h1f, t);
    chk_rng(t, 44, 53);
    tick(5);
    host.wr(rsr_pkg::ADDR_RAMP_CTRL, 8'h06, 1'b1);
    host.setpt(6'h25, 6'h25);
    tick(200);
    chk({2'h0, o_core_a_code}, 8'h1f);
    chk({7'h0, o_ramp_busy}, 8'h00);
    chk({7'h0, o_linear_blank}, 8'h00);
    run_seq(1'b1);
    run_seq(1'b0);
    chk({2'h0, o_buck_boost_code}, 8'h05);
    i_rst_b = 1'b0;
    tick(2);
    chk({2'h0, o_linear_code}, 8'h1f);
    i_rst_b = 1'b1;
    tick(2);
    end_sim();
  end
endmodule
